//--- design/srwe_engine.sv
// Repeated-fill write command engine
// Notes on behaviour
// R1: Key word 0 value 0002h selects the repeated-fill write action.
// R2: Function 0001h is background pattern fill, 0002h background sector fill.
// R3: Function 0101h is blocking pattern fill, 0102h blocking sector fill.
// R4: Start address sits in key words 5:2, count in words 9:6.
// R5: Pattern forms write the 32-bit value from words 11:10.
// R6: Accepted command shows error 00h, transfer count 01h/00h, status 50h.
// R7: Blocks are written upward from the start address until count is done.
// R8: Count zero fills through the last user block.
// R9: Blocks beyond the last user block, hidden area included, are never written.
// R10: Media may reassign defective sectors during the fill.
// R11: Start or end past last user block reports error, writes nothing.
// R12: Host sends the fill sector once data readiness is shown.
// R13: Complete error-free whole-drive fill sets the full-write flag.
// R14: Any other user write clears the full-write flag.
// R15: Reallocations from reads leave the full-write flag alone.
// R16: Background form completes once the data has been received.
// R17: Background fill stops on any new command but the status query.
// R18: Result reads FFFFh while running, 0000h on success, between on early end.
// R19: Background result is 0008h on abort, 0009h on media failure.
// R20: Blocking form withholds completion until the fill has finished.
// R21: Errors show error 04h, status 51h, result bytes in count and number.
// R22: Blocking result is 0017h on media failure.
// R23: Status response carries the block address being processed.
// R24: Drive state reads 5 while a background fill runs.
// R25: Unknown function codes are refused with error outputs and no writes.
`timescale 1ns/1ps
`default_nettype none
`include "srwe_cfg.svh"
module srwe_engine #(
  parameter int SECT_WORDS = `SRWE_SECT_WORDS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic key_valid,
  input wire logic [15:0] key_word,
  input wire logic data_valid,
  input wire logic [15:0] data_word,
  input wire logic new_cmd_valid,
  input wire logic new_cmd_is_status,
  input wire logic host_user_write,
  input wire logic [63:0] last_user_lba,
  input wire logic media_wr_ack,
  input wire logic media_wr_fail,
  input wire logic [$clog2(SECT_WORDS)-1:0] media_rd_idx,
  output logic media_wr_req,
  output logic [63:0] media_wr_lba,
  output logic media_wr_sector,
  output logic [31:0] media_wr_pattern,
  output logic [15:0] media_rd_word,
  output logic data_request,
  output logic cmd_done,
  output logic [7:0] tfo_error,
  output logic [7:0] tfo_sect_cnt,
  output logic [7:0] tfo_sect_num,
  output logic [7:0] tfo_cyl_lo,
  output logic [7:0] tfo_cyl_hi,
  output logic [7:0] tfo_status,
  output logic [15:0] ext_status,
  output logic [63:0] cur_lba,
  output logic [7:0] drive_state,
  output logic full_write_flag
);
  localparam int IW = $clog2(SECT_WORDS);

  // ==========================================
  // Function code decoding
  function automatic logic fn_valid(input logic [15:0] fn);
    return (fn == `SRWE_FN_PAT_BG) || (fn == `SRWE_FN_SEC_BG) ||
           (fn == `SRWE_FN_PAT_BLK) || (fn == `SRWE_FN_SEC_BLK);
  endfunction

  function automatic logic fn_sector(input logic [15:0] fn);
    return (fn == `SRWE_FN_SEC_BG) || (fn == `SRWE_FN_SEC_BLK);
  endfunction

  function automatic logic fn_bg(input logic [15:0] fn);
    return (fn == `SRWE_FN_PAT_BG) || (fn == `SRWE_FN_SEC_BG);
  endfunction

  srwe_pkg::srwe_state_e state_reg;
  logic [7:0] key_idx_reg;
  logic [15:0] act_reg;
  logic [15:0] fn_reg;
  logic [63:0] start_reg;
  logic [63:0] count_reg;
  logic [31:0] pat_reg;
  logic [63:0] rem_reg;
  logic whole_reg;
  logic [IW-1:0] data_idx_reg;
  logic [15:0] sect_mem [SECT_WORDS];
  logic range_err;
  logic [63:0] fill_len;
  logic whole_drive;
  logic key_take;
  logic data_last;
  logic bad_cmd;
  logic is_bg;
  logic abort;
  logic fill_enter;
  logic fill_fail;
  logic fill_ok;
  logic fill_exit;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  srwe_range_chk #(.AW(64)) u_range (
    .first_block_address(start_reg),
    .count(count_reg),
    .last_lba(last_user_lba),
    .range_err(range_err),
    .fill_len(fill_len),
    .whole_drive(whole_drive)
  );

  assign is_bg = fn_bg(fn_reg);
  assign key_take = key_valid && ((state_reg == srwe_pkg::ST_IDLE) || (state_reg == srwe_pkg::ST_KEY));
  assign data_last = (state_reg == srwe_pkg::ST_DATA) && data_valid && (data_idx_reg == IW'(SECT_WORDS - 1));
  assign bad_cmd = (act_reg != `SRWE_ACT_FILL) || !fn_valid(fn_reg) || range_err; // R1 R25 R11 R9
  assign fill_enter = ((state_reg == srwe_pkg::ST_CHECK) && !bad_cmd && !fn_sector(fn_reg)) || data_last;
  assign abort = (state_reg == srwe_pkg::ST_FILL) && is_bg && new_cmd_valid && !new_cmd_is_status; // R17
  assign fill_fail = (state_reg == srwe_pkg::ST_FILL) && !abort && media_wr_ack && media_wr_fail;
  assign fill_ok = (state_reg == srwe_pkg::ST_FILL) && !abort && media_wr_ack && !media_wr_fail &&
                   (rem_reg == 64'h1);
  assign fill_exit = abort || fill_fail || fill_ok;

  // ==========================================
  // Key sector capture, little-endian words shifted in
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      key_idx_reg <= 8'h00;
      act_reg <= 16'h0000;
      fn_reg <= 16'h0000;
      start_reg <= 64'h0;
      count_reg <= 64'h0;
      pat_reg <= 32'h0;
    end else if (key_take) begin
      key_idx_reg <= key_idx_reg + 8'h01;
      if (key_idx_reg == `SRWE_W_ACT) begin
        act_reg <= key_word; // R1
      end
      if (key_idx_reg == `SRWE_W_FN) begin
        fn_reg <= key_word; // R2 R3
      end
      if ((key_idx_reg >= `SRWE_W_LBA) && (key_idx_reg < `SRWE_W_CNT)) begin
        start_reg <= {key_word, start_reg[63:16]}; // R4
      end
      if ((key_idx_reg >= `SRWE_W_CNT) && (key_idx_reg < `SRWE_W_PAT)) begin
        count_reg <= {key_word, count_reg[63:16]}; // R4
      end
      if ((key_idx_reg >= `SRWE_W_PAT) && (key_idx_reg < `SRWE_W_END)) begin
        pat_reg <= {key_word, pat_reg[31:16]}; // R5
      end
    end else if (state_reg == srwe_pkg::ST_IDLE) begin
      key_idx_reg <= 8'h00;
    end
  end

  // ==========================================
  // Command sequence
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= srwe_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        srwe_pkg::ST_IDLE: begin
          if (key_valid) begin
            state_reg <= srwe_pkg::ST_KEY;
          end
        end
        srwe_pkg::ST_KEY: begin
          if (key_valid && (key_idx_reg == `SRWE_KEY_LAST)) begin
            state_reg <= srwe_pkg::ST_CHECK;
          end
        end
        srwe_pkg::ST_CHECK: begin
          if (bad_cmd) begin
            state_reg <= srwe_pkg::ST_IDLE; // R11 R25
          end else if (fn_sector(fn_reg)) begin
            state_reg <= srwe_pkg::ST_DATA;
          end else begin
            state_reg <= srwe_pkg::ST_FILL;
          end
        end
        srwe_pkg::ST_DATA: begin
          if (data_last) begin
            state_reg <= srwe_pkg::ST_FILL;
          end
        end
        srwe_pkg::ST_FILL: begin
          if (fill_exit) begin
            state_reg <= srwe_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Fill sector buffer
  always_ff @(posedge clk_sys) begin
    if ((state_reg == srwe_pkg::ST_DATA) && data_valid) begin
      sect_mem[data_idx_reg] <= data_word; // R12
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      data_idx_reg <= '0;
      media_rd_word <= 16'h0000;
    end else begin
      media_rd_word <= sect_mem[media_rd_idx];
      if (state_reg != srwe_pkg::ST_DATA) begin
        data_idx_reg <= '0;
      end else if (data_valid) begin
        data_idx_reg <= data_idx_reg + IW'(1);
      end
    end
  end

  // ==========================================
  // Media write walk; bad sectors are remapped below this port
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      media_wr_req <= 1'b0;
      media_wr_lba <= 64'h0;
      media_wr_sector <= 1'b0;
      media_wr_pattern <= 32'h0;
      rem_reg <= 64'h0;
      whole_reg <= 1'b0;
    end else if (state_reg == srwe_pkg::ST_CHECK) begin
      media_wr_lba <= start_reg;
      rem_reg <= fill_len; // R8
      whole_reg <= whole_drive;
      media_wr_sector <= fn_sector(fn_reg);
      media_wr_pattern <= pat_reg; // R5
      media_wr_req <= !bad_cmd && !fn_sector(fn_reg); // R11
    end else if (fill_enter) begin
      media_wr_req <= 1'b1;
    end else if (fill_exit) begin
      media_wr_req <= 1'b0;
    end else if ((state_reg == srwe_pkg::ST_FILL) && media_wr_ack) begin // R10
      media_wr_lba <= media_wr_lba + 64'h1; // R7
      rem_reg <= rem_reg - 64'h1;
    end
  end

  assign cur_lba = media_wr_lba; // R23

  // ==========================================
  // Task file outputs and result code
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_done <= 1'b0;
      data_request <= 1'b0;
      tfo_error <= `SRWE_ERR_NONE;
      tfo_sect_cnt <= `SRWE_ZERO8;
      tfo_sect_num <= `SRWE_ZERO8;
      tfo_cyl_lo <= `SRWE_ZERO8;
      tfo_cyl_hi <= `SRWE_ZERO8;
      tfo_status <= `SRWE_STAT_OK;
      ext_status <= `SRWE_ES_OK;
    end else begin
      cmd_done <= 1'b0;
      if ((state_reg == srwe_pkg::ST_CHECK) && bad_cmd) begin
        tfo_error <= `SRWE_ERR_ABRT; // R21
        tfo_status <= `SRWE_STAT_ERR;
        {tfo_sect_num, tfo_sect_cnt} <= range_err ? `SRWE_ES_RANGE : `SRWE_ES_BADCMD;
        ext_status <= range_err ? `SRWE_ES_RANGE : `SRWE_ES_BADCMD;
        cmd_done <= 1'b1;
      end else if (state_reg == srwe_pkg::ST_CHECK) begin
        tfo_error <= `SRWE_ERR_NONE; // R6
        tfo_status <= `SRWE_STAT_OK;
        tfo_sect_cnt <= `SRWE_ZERO8;
        tfo_sect_num <= `SRWE_ZERO8;
        tfo_cyl_lo <= `SRWE_XFER_LO;
        tfo_cyl_hi <= `SRWE_XFER_HI;
        ext_status <= `SRWE_ES_RUN; // R18
        data_request <= fn_sector(fn_reg);
        cmd_done <= is_bg && !fn_sector(fn_reg); // R16
      end else if (data_last) begin
        data_request <= 1'b0;
        cmd_done <= is_bg; // R16 R20
      end else if (abort) begin
        ext_status <= `SRWE_ES_ABORT; // R19
      end else if (fill_fail) begin
        ext_status <= is_bg ? `SRWE_ES_BG_FAIL : `SRWE_ES_BLK_FAIL; // R19 R22
        if (!is_bg) begin
          tfo_error <= `SRWE_ERR_ABRT; // R21
          tfo_status <= `SRWE_STAT_ERR;
          {tfo_sect_num, tfo_sect_cnt} <= `SRWE_ES_BLK_FAIL;
          cmd_done <= 1'b1;
        end
      end else if (fill_ok) begin
        ext_status <= `SRWE_ES_OK; // R18
        cmd_done <= !is_bg; // R20
      end
    end
  end

  // ==========================================
  // Drive state and full-write flag
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      drive_state <= `SRWE_DS_IDLE;
    end else if (fill_enter) begin
      drive_state <= is_bg ? `SRWE_DS_FILL : `SRWE_DS_IDLE; // R24
    end else if (fill_exit) begin
      drive_state <= `SRWE_DS_IDLE;
    end
  end

  // Only writes touch the flag; read reallocations have no path here
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      full_write_flag <= 1'b0;
    end else if (fill_ok && whole_reg) begin
      full_write_flag <= 1'b1; // R13
    end else if (fill_enter || host_user_write) begin
      full_write_flag <= 1'b0; // R14 R15
    end
  end

  // ==========================================
  // Checks
  a_wr_bounded: assert property (media_wr_req |-> media_wr_lba <= last_user_lba) // R9
    else $error("media write beyond last user block");
  a_range_nowr: assert property ((state_reg == srwe_pkg::ST_CHECK) && range_err |=> !media_wr_req && tfo_status == 8'h51) // R11
    else $error("out of range command wrote or did not fail");
  a_lba_step: assert property ((state_reg == srwe_pkg::ST_FILL) && media_wr_ack && !fill_exit |=> media_wr_req && media_wr_lba == $past(media_wr_lba) + 64'h1) // R7
    else $error("block address did not step by one");
  a_run_code: assert property ((state_reg == srwe_pkg::ST_FILL) |-> ext_status == 16'hffff) // R18
    else $error("result not running code during fill");
  a_ok_code: assert property (fill_ok |=> ext_status == 16'h0000 && !media_wr_req) // R18
    else $error("success code missing");
  a_abort_code: assert property (abort |=> ext_status == 16'h0008 && !media_wr_req && state_reg == srwe_pkg::ST_IDLE) // R17
    else $error("abort did not stop fill");
  a_bg_fail: assert property (fill_fail && is_bg |=> ext_status == 16'h0009 && !cmd_done) // R19
    else $error("background failure code wrong");
  a_blk_fail: assert property (fill_fail && !is_bg |=> ext_status == 16'h0017 && cmd_done && tfo_sect_cnt == 8'h17) // R22
    else $error("blocking failure report wrong");
  a_blk_hold: assert property ((state_reg == srwe_pkg::ST_FILL) && !is_bg |-> !cmd_done) // R20
    else $error("blocking completion before fill end");
  a_bg_done: assert property (data_last && is_bg |=> cmd_done && tfo_status == 8'h50 && media_wr_req) // R16
    else $error("background completion not at data end");
  a_ok_regs: assert property (cmd_done && tfo_status == 8'h50 |-> tfo_error == 8'h00 && tfo_cyl_lo == 8'h01 && tfo_cyl_hi == 8'h00) // R6
    else $error("success outputs wrong");
  a_err_regs: assert property (cmd_done && tfo_status == 8'h51 |-> tfo_error == 8'h04 && {tfo_sect_num, tfo_sect_cnt} == ext_status) // R21
    else $error("error outputs wrong");
  a_flag_set: assert property (fill_ok && whole_reg |=> full_write_flag) // R13
    else $error("full-write flag not set");
  a_flag_clr: assert property (host_user_write && !(fill_ok && whole_reg) |=> !full_write_flag) // R14
    else $error("full-write flag not cleared");
  a_state_five: assert property ((state_reg == srwe_pkg::ST_FILL) && is_bg |-> drive_state == 8'h05) // R24
    else $error("drive state not five in background fill");
  a_bad_fn: assert property ((state_reg == srwe_pkg::ST_CHECK) && !fn_valid(fn_reg) |=> state_reg == srwe_pkg::ST_IDLE && !media_wr_req) // R25
    else $error("bad function accepted");

  c_bg_ok: cover property (fill_ok && is_bg);
  c_abort: cover property (abort);
  c_blk_sector: cover property (fill_ok && !is_bg && media_wr_sector);
  c_whole: cover property (fill_ok && whole_reg);
endmodule
`default_nettype wire

//--- pkg/srwe_cfg.svh
// Constants of the repeated-fill write engine
`ifndef SRWE_CFG_SVH
`define SRWE_CFG_SVH
// ==========================================
// Key sector layout
`define SRWE_W_ACT 8'h00
`define SRWE_W_FN 8'h01
`define SRWE_W_LBA 8'h02
`define SRWE_W_CNT 8'h06
`define SRWE_W_PAT 8'h0a
`define SRWE_W_END 8'h0c
`define SRWE_KEY_LAST 8'hff
`define SRWE_SECT_WORDS 256
// ==========================================
// Action and function codes
`define SRWE_ACT_FILL 16'h0002
`define SRWE_FN_PAT_BG 16'h0001
`define SRWE_FN_SEC_BG 16'h0002
`define SRWE_FN_PAT_BLK 16'h0101
`define SRWE_FN_SEC_BLK 16'h0102
// ==========================================
// Result codes
`define SRWE_ES_OK 16'h0000
`define SRWE_ES_RUN 16'hffff
`define SRWE_ES_ABORT 16'h0008
`define SRWE_ES_BG_FAIL 16'h0009
`define SRWE_ES_BLK_FAIL 16'h0017
`define SRWE_ES_RANGE 16'h0003
`define SRWE_ES_BADCMD 16'h0004
// ==========================================
// Task file output and drive state values
`define SRWE_ERR_NONE 8'h00
`define SRWE_ERR_ABRT 8'h04
`define SRWE_STAT_OK 8'h50
`define SRWE_STAT_ERR 8'h51
`define SRWE_XFER_LO 8'h01
`define SRWE_XFER_HI 8'h00
`define SRWE_ZERO8 8'h00
`define SRWE_DS_IDLE 8'h00
`define SRWE_DS_FILL 8'h05
`endif

//--- pkg/srwe_pkg.sv
// Types shared by the repeated-fill write engine
`default_nettype none
package srwe_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_KEY   = 5'h02,
    ST_CHECK = 5'h04,
    ST_DATA  = 5'h08,
    ST_FILL  = 5'h10
  } srwe_state_e;
endpackage
`default_nettype wire

//--- design/srwe_range_chk.sv
// Block range check and fill length for the fill engine
`timescale 1ns/1ps
`default_nettype none
module srwe_range_chk #(
  parameter int AW = 64
) (
  input wire logic [AW-1:0] first_block_address,
  input wire logic [AW-1:0] count,
  input wire logic [AW-1:0] last_lba,
  output logic range_err,
  output logic [AW-1:0] fill_len,
  output logic whole_drive
);
  logic [AW:0] end_excl;
  logic [AW:0] limit_excl;
  // Widened by one bit so a huge count cannot wrap past the limit
  assign end_excl = {1'b0, first_block_address} + {1'b0, count};
  assign limit_excl = {1'b0, last_lba} + {{AW{1'b0}}, 1'b1};
  assign range_err = (first_block_address > last_lba) || ((count != '0) && (end_excl > limit_excl));
  assign fill_len = (count == '0) ? AW'(limit_excl - {1'b0, first_block_address}) : count;
  assign whole_drive = (first_block_address == '0) && ({1'b0, fill_len} == limit_excl);
endmodule
`default_nettype wire

//--- tb/srwe_media_model.sv
// Media-side partner model for the fill engine
`timescale 1ns/1ps
`default_nettype none
module srwe_media_model #(
  parameter int IW = 3
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic media_wr_req,
  input wire logic [63:0] media_wr_lba,
  input wire logic [63:0] last_user_lba,
  input wire logic [7:0] ack_delay,
  input wire logic fail_en,
  input wire logic [63:0] fail_lba,
  output logic media_wr_ack,
  output logic media_wr_fail,
  output logic [IW-1:0] media_rd_idx,
  output var int wr_cnt,
  output logic [63:0] wr_last,
  output var int wr_bad
);
  logic [7:0] wait_reg;
  logic run_reg;
  // =====
  // Acknowledge after a programmable wait
  assign media_wr_ack = media_wr_req && (wait_reg >= ack_delay);
  // Fail only means something with ack, so it wanders otherwise
  assign media_wr_fail = media_wr_ack ? (fail_en && media_wr_lba == fail_lba) : wait_reg[0];
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_reg <= 8'h00;
      media_rd_idx <= '0;
    end else begin
      wait_reg <= (!media_wr_req || media_wr_ack) ? 8'h00 : wait_reg + 8'h01;
      media_rd_idx <= media_rd_idx + 1'b1;
    end
  end
  // =====
  // Write log with order and bound checks
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      run_reg <= 1'b0;
      wr_cnt <= 0;
      wr_bad <= 0;
      wr_last <= 64'h0;
    end else begin
      run_reg <= media_wr_req && (run_reg || media_wr_ack);
      if (media_wr_ack) begin
        wr_cnt <= wr_cnt + 1;
        wr_last <= media_wr_lba;
        if ((run_reg && media_wr_lba != wr_last + 64'h1) || media_wr_lba > last_user_lba) begin
          wr_bad <= wr_bad + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the repeated-fill write engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SW = 8;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic key_valid = 1'b0;
  logic [15:0] key_word = 16'h0000;
  logic data_valid = 1'b0;
  logic [15:0] data_word = 16'h0000;
  logic new_cmd_valid = 1'b0;
  logic new_cmd_is_status = 1'b0;
  logic host_user_write = 1'b0;
  logic [63:0] last_user_lba = 64'h7;
  logic [7:0] ack_delay = 8'h00;
  logic fail_en = 1'b0;
  logic [63:0] fail_lba = 64'h0;
  logic media_wr_ack, media_wr_fail, media_wr_req, media_wr_sector, data_request, cmd_done, full_write_flag;
  logic [2:0] media_rd_idx;
  logic [63:0] media_wr_lba, cur_lba, wr_last;
  logic [31:0] media_wr_pattern;
  logic [15:0] media_rd_word, ext_status;
  logic [7:0] tfo_error, tfo_sect_cnt, tfo_sect_num, tfo_cyl_lo, tfo_cyl_hi, tfo_status, drive_state;
  int wr_cnt, wr_bad, done_cnt = 0, cycles = 0, mismatches = 0, total_checks = 0;

  srwe_engine #(.SECT_WORDS(SW)) srwe_engine_inst (.clk_sys, .reset, .key_valid, .key_word, .data_valid,
    .data_word, .new_cmd_valid, .new_cmd_is_status, .host_user_write, .last_user_lba, .media_wr_ack,
    .media_wr_fail, .media_rd_idx, .media_wr_req, .media_wr_lba, .media_wr_sector, .media_wr_pattern,
    .media_rd_word, .data_request, .cmd_done, .tfo_error, .tfo_sect_cnt, .tfo_sect_num, .tfo_cyl_lo,
    .tfo_cyl_hi, .tfo_status, .ext_status, .cur_lba, .drive_state, .full_write_flag);
  srwe_media_model #(.IW(3)) srwe_media_model_inst (.clk_sys, .reset, .media_wr_req, .media_wr_lba,
    .last_user_lba, .ack_delay, .fail_en, .fail_lba, .media_wr_ack, .media_wr_fail, .media_rd_idx,
    .wr_cnt, .wr_last, .wr_bad);

  // =====
  // Clock, completion count and hang guard
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cmd_done === 1'b1) done_cnt++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic ck(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic send_key(input logic [15:0] act, fn, input logic [63:0] st, cn, input logic [31:0] pat);
    logic [191:0] k;
    k = {pat, cn, st, fn, act};
    for (int i = 0; i < 256; i++) begin
      step(1);
      key_valid = 1'b1;
      key_word = (i < 12) ? k[i*16 +: 16] : 16'h0000;
    end
    step(1);
    key_valid = 1'b0;
  endtask

  // Two edges after the request drops so a late completion is counted
  task automatic wait_fill();
    for (int i = 0; i < 3000 && media_wr_req === 1'b1; i++) step(1);
    step(2);
  endtask

  // =====
  // Scenarios
  task automatic t_bg_pat();
    int n0;
    n0 = wr_cnt;
    ack_delay = 8'h02;
    send_key(16'h0002, 16'h0001, 64'h4, 64'h4, 32'hcafe1234);
    step(1);
    ck(cmd_done, 1, "bg done at accept");
    ck({tfo_error, tfo_cyl_lo, tfo_cyl_hi, tfo_status}, 32'h00010050, "accept outputs");
    ck(ext_status, 16'hffff, "running code");
    ck(drive_state, 8'h05, "drive state");
    ck({media_wr_sector, media_wr_pattern}, 33'h0cafe1234, "pattern");
    step(5);
    ck(cur_lba, 64'h4 + 64'(wr_cnt - n0), "current block");
    wait_fill();
    ck(wr_cnt - n0, 4, "write count");
    ck(wr_last, 64'h7, "last block");
    ck(ext_status, 16'h0000, "done code");
    ck(drive_state, 8'h00, "state after");
  endtask

  task automatic t_blk_whole();
    int n0, d0;
    n0 = wr_cnt;
    d0 = done_cnt;
    ack_delay = 8'h01;
    send_key(16'h0002, 16'h0101, 64'h0, 64'h0, 32'h5a5a0f0f);
    step(4);
    ck(done_cnt - d0, 0, "blocking withheld");
    ck(media_wr_req, 1, "blocking writes");
    wait_fill();
    ck(done_cnt - d0, 1, "blocking done");
    ck(wr_cnt - n0, 8, "whole count");
    ck(wr_last, 64'h7, "whole last");
    ck(wr_bad, 0, "order or bound");
    ck(full_write_flag, 1, "flag set");
    host_user_write = 1'b1;
    step(1);
    host_user_write = 1'b0;
    step(1);
    ck(full_write_flag, 0, "flag cleared");
  endtask

  task automatic t_abort();
    ack_delay = 8'h04;
    send_key(16'h0002, 16'h0001, 64'h0, 64'h0, 32'h00000001);
    step(8);
    new_cmd_valid = 1'b1;
    new_cmd_is_status = 1'b1;
    step(1);
    new_cmd_valid = 1'b0;
    new_cmd_is_status = 1'b0;
    step(1);
    ck({media_wr_req, ext_status}, 17'h1ffff, "status query kept fill");
    new_cmd_valid = 1'b1;
    step(1);
    new_cmd_valid = 1'b0;
    ck({media_wr_req, ext_status}, 17'h00008, "abort code");
    ck({drive_state, full_write_flag}, 9'h000, "after abort");
  endtask

  task automatic t_errors();
    logic [15:0] ac [4] = '{16'h0002, 16'h0002, 16'h0003, 16'h0002};
    logic [15:0] fc [4] = '{16'h0001, 16'h0101, 16'h0001, 16'h0003};
    logic [63:0] sc [4] = '{64'h8, 64'h5, 64'h0, 64'h0};
    logic [63:0] cc [4] = '{64'h0, 64'h4, 64'h1, 64'h1};
    logic [15:0] ec [4] = '{16'h0003, 16'h0003, 16'h0004, 16'h0004};
    int n0, d0;
    for (int i = 0; i < 4; i++) begin
      n0 = wr_cnt;
      d0 = done_cnt;
      send_key(ac[i], fc[i], sc[i], cc[i], 32'h0);
      step(4);
      ck(done_cnt - d0, 1, "error reported");
      ck({tfo_error, tfo_sect_cnt, tfo_sect_num, tfo_status}, {8'h04, ec[i][7:0], ec[i][15:8], 8'h51}, "error outputs");
      ck({media_wr_req, ext_status}, {1'b0, ec[i]}, "error code");
      ck(wr_cnt - n0, 0, "no writes");
    end
  endtask

  task automatic t_fail(input logic [15:0] fn, input logic [15:0] code);
    int d0;
    d0 = done_cnt;
    ack_delay = 8'h00;
    fail_en = 1'b1;
    fail_lba = 64'h5;
    send_key(16'h0002, fn, 64'h4, 64'h4, 32'h00000077);
    step(2);
    wait_fill();
    fail_en = 1'b0;
    ck(ext_status, code, "failure code");
    ck(wr_last, 64'h5, "stopped at fail");
    ck(done_cnt - d0, 1, "one completion");
    ck({tfo_error, tfo_status}, fn[8] ? 16'h0451 : 16'h0050, "fail outputs");
    if (fn[8]) ck({tfo_sect_cnt, tfo_sect_num}, 16'h1700, "code bytes");
  endtask

  task automatic t_sector(input logic [15:0] fn);
    int n0, d0;
    logic [2:0] pi;
    n0 = wr_cnt;
    d0 = done_cnt;
    ack_delay = 8'h03;
    send_key(16'h0002, fn, 64'h2, 64'h3, 32'h0);
    step(2);
    ck({data_request, media_wr_req}, 2'b10, "ready for data");
    for (int i = 0; i < SW; i++) begin
      data_valid = 1'b1;
      data_word = 16'hd000 + 16'(i);
      step(1);
    end
    data_valid = 1'b0;
    ck({data_request, media_wr_sector}, 2'b01, "data taken");
    ck(cmd_done, !fn[8], "done after data");
    // Last word lands at the same edge as a read of it
    step(1);
    pi = media_rd_idx - 3'h1;
    ck(media_rd_word, 16'hd000 + {13'h0000, pi}, "buffered word");
    wait_fill();
    ck(wr_cnt - n0, 3, "sector writes");
    ck(ext_status, 16'h0000, "sector ok");
    ck(done_cnt - d0, 1, "sector completion");
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    ck({tfo_status, ext_status, media_wr_req, cmd_done}, 26'h1400000, "reset values");
    t_bg_pat();
    t_blk_whole();
    t_abort();
    t_errors();
    t_fail(16'h0001, 16'h0009);
    t_fail(16'h0101, 16'h0017);
    t_sector(16'h0002);
    t_sector(16'h0102);
    tally_and_finish();
  end
endmodule
`default_nettype wire
